// File: hdl/dual_slope_map.vh
// register map, field positions, reset values and phase counts of the conversion sequencer
`ifndef DUAL_SLOPE_MAP_VH
`define DUAL_SLOPE_MAP_VH
`define DS_OFF_CTRL 12'h000
`define DS_OFF_STATUS 12'h004
`define DS_OFF_RESULT 12'h008
`define DS_OFF_LAST 12'h00c
`define DS_CTRL_PEAK_BIT 0
`define DS_CTRL_RANGE_BIT 1
`define DS_CTRL_RESET 2'h0
`define DS_ST_PHASE_LSB 0
`define DS_ST_PHASE_MSB 1
`define DS_ST_POL_BIT 2
`define DS_ST_OVR_BIT 3
`define DS_ST_GT_BIT 4
`define DS_ST_DEINT_BIT 5
`define DS_RES_CNT_MSB 12
`define DS_RES_POL_BIT 13
`define DS_RES_OVR_BIT 14
`define DS_CYCLE_COUNTS 13'h1f40
`define DS_AZ_COUNTS 13'h05dc
`define DS_INT_COUNTS 13'h07d0
`define DS_INT_SHORT_COUNTS 13'h00c8
`define DS_DE_MAX_COUNTS 13'h0fa1
`define DS_ZI_MIN_COUNTS 13'h01f4
`define DS_GT_HOLD_CLKS 6'h32
`endif

// File: hdl/dual_slope_conversion_sequencer.v
// dual-slope integrating converter sequencer with apb register slave
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "dual_slope_map.vh"
module dual_slope_conversion_sequencer #(
	parameter [12:0] CYCLE_COUNTS = `DS_CYCLE_COUNTS,
	parameter [12:0] AZ_COUNTS = `DS_AZ_COUNTS,
	parameter [12:0] INT_COUNTS = `DS_INT_COUNTS,
	parameter [12:0] INT_SHORT_COUNTS = `DS_INT_SHORT_COUNTS,
	parameter [12:0] DE_MAX_COUNTS = `DS_DE_MAX_COUNTS,
	parameter [12:0] ZI_MIN_COUNTS = `DS_ZI_MIN_COUNTS,
	parameter [5:0] GT_HOLD_CLKS = `DS_GT_HOLD_CLKS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire comparator_in,
	output reg zero_int_sw,
	output reg offset_store_cap_loop,
	output reg input_connect,
	output reg ref_pos_connect,
	output reg ref_neg_connect,
	output reg deint_status,
	output reg conv_done,
	output reg greater_than_flag,
	output reg [12:0] display_count,
	output reg display_polarity,
	output reg display_overrange
);
	localparam [1:0] PH_ZERO = 2'h0;
	localparam [1:0] PH_AZ = 2'h1;
	localparam [1:0] PH_INT = 2'h2;
	localparam [1:0] PH_DE = 2'h3;
	localparam [12:0] CYC_START = AZ_COUNTS + INT_COUNTS + DE_MAX_COUNTS - 13'h0001;

	// true when magnitude a is strictly above magnitude b
	function mag_above;
		input [12:0] a;
		input [12:0] b;
		begin
			mag_above = (a > b);
		end
	endfunction

	// switch pattern: zero, loop, input, ref pos, ref neg
	function [4:0] switch_decode;
		input [1:0] ph;
		input pol;
		begin
			case (ph)
				PH_ZERO: switch_decode = 5'h10;
				PH_AZ: switch_decode = 5'h08;
				PH_INT: switch_decode = 5'h04;
				PH_DE: switch_decode = pol ? 5'h01 : 5'h02;
				default: switch_decode = 5'h10;
			endcase
		end
	endfunction

	reg [1:0] ctrl_reg;
	reg tick_reg;
	reg comp_meta_reg;
	reg comp_sync_reg;
	reg [1:0] phase_reg;
	reg [1:0] phase_next;
	reg [12:0] cyc_reg;
	reg [12:0] cyc_next;
	reg [12:0] de_reg;
	reg [12:0] de_next;
	reg pol_reg;
	reg pol_next;
	reg conv_end;
	reg ovr_now;
	reg [12:0] last_count_reg;
	reg last_pol_reg;
	reg last_ovr_reg;
	reg [5:0] gt_cnt_reg;
	reg [31:0] rd_mux;
	reg mapped;

	wire peak_keep_select = ctrl_reg[`DS_CTRL_PEAK_BIT];
	wire range_divide_input = ctrl_reg[`DS_CTRL_RANGE_BIT];
	wire [12:0] int_len = range_divide_input ? INT_SHORT_COUNTS : INT_COUNTS;
	wire [12:0] int_last = AZ_COUNTS + int_len - 13'h0001;
	wire crossing = (comp_sync_reg != pol_reg);
	wire apb_setup = psel & ~penable;
	wire apb_write = psel & penable & pready & pwrite;
	wire [4:0] sw_next = switch_decode(phase_next, pol_next);

	// phase sequencing on count ticks only
	always @* begin
		phase_next = phase_reg;
		cyc_next = cyc_reg;
		de_next = de_reg;
		pol_next = pol_reg;
		conv_end = 1'b0;
		ovr_now = 1'b0;
		if (tick_reg) begin
			// free cycle counter fixes total length whatever the input
			if (cyc_reg == CYCLE_COUNTS - 13'h0001) begin
				cyc_next = 13'h0000;
			end else begin
				cyc_next = cyc_reg + 13'h0001;
			end
			case (phase_reg)
				PH_ZERO: begin
					// ends at cycle wrap, so it absorbs unused deintegrate counts
					if (cyc_reg == CYCLE_COUNTS - 13'h0001) begin
						phase_next = PH_AZ;
					end
				end
				PH_AZ: begin
					if (cyc_reg == AZ_COUNTS - 13'h0001) begin
						phase_next = PH_INT;
					end
				end
				PH_INT: begin
					if (cyc_reg == int_last) begin
						phase_next = PH_DE;
						de_next = 13'h0000;
						pol_next = comp_sync_reg;
					end
				end
				PH_DE: begin
					de_next = de_reg + 13'h0001;
					if (crossing || de_next == DE_MAX_COUNTS) begin
						phase_next = PH_ZERO;
						conv_end = 1'b1;
						ovr_now = ~crossing;
					end
				end
				default: begin
					phase_next = PH_ZERO;
				end
			endcase
		end
	end

	// count enable and comparator synchroniser
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 1'b0;
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			tick_reg <= ~tick_reg;
			// comparator is asynchronous to pclk
			comp_meta_reg <= comparator_in;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	// phase state and switch drive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= PH_ZERO;
			// first zero phase after reset is one count longer than the minimum span
			cyc_reg <= CYC_START;
			de_reg <= 13'h0000;
			pol_reg <= 1'b0;
			zero_int_sw <= 1'b1;
			offset_store_cap_loop <= 1'b0;
			input_connect <= 1'b0;
			ref_pos_connect <= 1'b0;
			ref_neg_connect <= 1'b0;
			deint_status <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			cyc_reg <= cyc_next;
			de_reg <= de_next;
			pol_reg <= pol_next;
			zero_int_sw <= sw_next[4];
			offset_store_cap_loop <= sw_next[3];
			input_connect <= sw_next[2];
			ref_pos_connect <= sw_next[1];
			ref_neg_connect <= sw_next[0];
			deint_status <= (phase_next == PH_DE);
			conv_done <= conv_end;
		end
	end

	// result capture and display register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_count_reg <= 13'h0000;
			last_pol_reg <= 1'b0;
			last_ovr_reg <= 1'b0;
			display_count <= 13'h0000;
			display_polarity <= 1'b0;
			display_overrange <= 1'b0;
		end else begin
			// overrange keeps the full span, so it compares as largest
			if (conv_end) begin
				last_count_reg <= de_next;
				last_pol_reg <= pol_reg;
				last_ovr_reg <= ovr_now;
			end
			// display moves as conv_done falls
			if (conv_done && (!peak_keep_select || mag_above(last_count_reg, display_count))) begin
				display_count <= last_count_reg;
				display_polarity <= last_pol_reg;
				display_overrange <= last_ovr_reg;
			end
		end
	end

	// greater-than flag and its hold timer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			greater_than_flag <= 1'b0;
			gt_cnt_reg <= 6'h00;
		end else begin
			if (conv_done) begin
				gt_cnt_reg <= GT_HOLD_CLKS;
			end else if (gt_cnt_reg != 6'h00) begin
				gt_cnt_reg <= gt_cnt_reg - 6'h01;
			end
			// set beats the timed clear
			if (conv_end && mag_above(de_next, display_count)) begin
				greater_than_flag <= 1'b1;
			end else if (gt_cnt_reg == 6'h01 && !conv_done) begin
				greater_than_flag <= 1'b0;
			end
		end
	end

	// read mux; reserved bits read zero
	always @* begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`DS_OFF_CTRL: rd_mux[1:0] = ctrl_reg;
			`DS_OFF_STATUS: begin
				rd_mux[`DS_ST_PHASE_MSB:`DS_ST_PHASE_LSB] = phase_reg;
				rd_mux[`DS_ST_POL_BIT] = pol_reg;
				rd_mux[`DS_ST_OVR_BIT] = last_ovr_reg;
				rd_mux[`DS_ST_GT_BIT] = greater_than_flag;
				rd_mux[`DS_ST_DEINT_BIT] = deint_status;
			end
			`DS_OFF_RESULT: begin
				rd_mux[`DS_RES_CNT_MSB:0] = display_count;
				rd_mux[`DS_RES_POL_BIT] = display_polarity;
				rd_mux[`DS_RES_OVR_BIT] = display_overrange;
			end
			`DS_OFF_LAST: begin
				rd_mux[`DS_RES_CNT_MSB:0] = last_count_reg;
				rd_mux[`DS_RES_POL_BIT] = last_pol_reg;
				rd_mux[`DS_RES_OVR_BIT] = last_ovr_reg;
			end
			default: mapped = 1'b0;
		endcase
	end

	// zero-wait slave: data registered in setup, ready in the access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `DS_CTRL_RESET;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~mapped;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
			if (apb_write && paddr == `DS_OFF_CTRL) begin
				ctrl_reg <= pwdata[1:0];
			end
		end
	end
endmodule

// File: bench/ds_comparator_model.sv
// comparator model of the integrator seen from the sequencer
`timescale 1ns/1ns
module ds_comparator_model (
	input wire pclk,
	input wire input_connect,
	input wire deint_status,
	input wire pol,
	input wire [12:0] k,
	output logic comparator_in
);
	int n = 0;
	logic flip = 1'b0;
	// k of zero never crosses, which forces overrange
	always @(posedge pclk) begin
		if (input_connect) begin
			n <= 0;
			flip <= 1'b0;
		end else if (deint_status) begin
			n <= n + 1;
			if (k != 0 && n + 1 == 2 * k)
				flip <= 1'b1;
		end
	end
	assign comparator_in = flip ? ~pol : pol;
endmodule

// File: bench/dual_slope_conversion_sequencer_sva.sv
// port assertions of the conversion sequencer
`timescale 1ns/1ns
module ds_seq_sva #(
	parameter [12:0] CYCLE_COUNTS = 13'h1f40,
	parameter [12:0] AZ_COUNTS = 13'h05dc,
	parameter [5:0] GT_HOLD_CLKS = 6'h32
) (
	input wire pclk,
	input wire presetn,
	input wire zero_int_sw,
	input wire offset_store_cap_loop,
	input wire input_connect,
	input wire ref_pos_connect,
	input wire ref_neg_connect,
	input wire deint_status,
	input wire conv_done,
	input wire greater_than_flag
);
	logic [15:0] az_n, cyc, gt_n;
	logic armed;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// first cycle after reset is short, so only later ones are timed
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			az_n <= 16'h0;
			cyc <= 16'h0;
			gt_n <= 16'h0;
			armed <= 1'b0;
		end else begin
			az_n <= offset_store_cap_loop ? az_n + 16'h1 : 16'h0;
			gt_n <= greater_than_flag ? gt_n + 16'h1 : 16'h0;
			cyc <= $rose(offset_store_cap_loop) ? 16'h1 : cyc + 16'h1;
			if ($rose(offset_store_cap_loop))
				armed <= 1'b1;
		end
	end
	sequence s_az_end;
		$fell(offset_store_cap_loop);
	endsequence
	a_az_span: assert property (s_az_end |-> az_n == 2 * AZ_COUNTS)
		else $error("auto-zero length wrong");
	a_az_then_int: assert property (s_az_end |-> input_connect)
		else $error("integrate does not follow auto-zero");
	a_int_then_de: assert property ($fell(input_connect) |-> deint_status)
		else $error("deintegrate does not follow integrate");
	a_de_then_zero: assert property ($fell(deint_status) |-> ##[0:2] zero_int_sw)
		else $error("zero phase does not follow deintegrate");
	a_cycle_total: assert property ($rose(offset_store_cap_loop) && armed |-> cyc == 2 * CYCLE_COUNTS)
		else $error("cycle length wrong");
	a_one_phase: assert property ($onehot({zero_int_sw, offset_store_cap_loop, input_connect, deint_status}))
		else $error("phase outputs not one-hot");
	a_ref_sign: assert property ((ref_pos_connect | ref_neg_connect) == deint_status && !(ref_pos_connect & ref_neg_connect))
		else $error("reference switches wrong");
	a_done_pulse: assert property ($fell(deint_status) |-> ##[0:2] conv_done ##1 !conv_done)
		else $error("end pulse wrong");
	a_gt_hold: assert property ($fell(greater_than_flag) |-> gt_n == GT_HOLD_CLKS + 1)
		else $error("greater-than hold wrong");
endmodule
bind dual_slope_conversion_sequencer ds_seq_sva #(.CYCLE_COUNTS(CYCLE_COUNTS), .AZ_COUNTS(AZ_COUNTS),
	.GT_HOLD_CLKS(GT_HOLD_CLKS)) chk (.*);

// File: bench/dual_slope_conversion_sequencer_tb_top.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ns
module dual_slope_conversion_sequencer_tb_top;
	typedef struct packed {logic pk, rg, pol; logic [12:0] k, dk; logic dpol, dovr, gt;} row_t;
	row_t rows [6] = '{'{0, 0, 1, 10, 10, 1, 0, 1}, '{0, 0, 0, 30, 30, 0, 0, 1}, '{1, 0, 1, 20, 30, 0, 0, 0},
		'{1, 0, 1, 35, 35, 1, 0, 1}, '{1, 1, 0, 0, 41, 0, 1, 1}, '{0, 0, 1, 5, 5, 1, 0, 0}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comparator_in, zero_int_sw, offset_store_cap_loop;
	logic input_connect, ref_pos_connect, ref_neg_connect, deint_status, conv_done, greater_than_flag;
	logic display_polarity, display_overrange, m_pol, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [12:0] display_count, m_k;
	int n, miscompares = 0, compares = 0, cycles = 0;
	row_t r;
	dual_slope_conversion_sequencer #(.CYCLE_COUNTS(13'h0050), .AZ_COUNTS(13'h000f), .INT_COUNTS(13'h0014),
		.INT_SHORT_COUNTS(13'h0002), .DE_MAX_COUNTS(13'h0029)) dut (.*);
	ds_comparator_model model (.pclk(pclk), .input_connect(input_connect), .deint_status(deint_status), .pol(m_pol),
		.k(m_k), .comparator_in(comparator_in));
	task give_verdict;
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always #10 pclk = ~pclk;
	// whole run is about 1000 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			give_verdict;
		end
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, m_pol, m_k} = 0;
		repeat (5) @(posedge pclk);
		chk("zero_sw", zero_int_sw, 1);
		chk("conv_done", conv_done, 0);
		presetn <= 1'b1;
		apb(0, 12'h000, 0);
		chk("ctrl", q, 0);
		apb(0, 12'h010, 0);
		chk("pslverr", e, 1);
		chk("unmapped_data", q, 0);
		foreach (rows[i]) begin
			r = rows[i];
			apb(1, 12'h000, {30'h0, r.rg, r.pk});
			m_pol <= r.pol;
			m_k <= r.k;
			do @(posedge pclk); while (input_connect !== 1'b1);
			n = 0;
			do begin
				n++;
				@(posedge pclk);
			end while (input_connect === 1'b1);
			chk("int_len", n, r.rg ? 4 : 40);
			do @(posedge pclk); while (conv_done !== 1'b1);
			chk("greater_than", greater_than_flag, r.gt);
			repeat (2) @(posedge pclk);
			chk("display", display_count >= r.dk && display_count <= r.dk + 3, 1);
			chk("polarity", display_polarity, r.dpol);
			chk("overrange", display_overrange, r.dovr);
		end
		apb(0, 12'h008, 0);
		chk("result", q[14:13], 2'h1);
		apb(0, 12'h00c, 0);
		chk("last", q[14:13], 2'h1);
		apb(0, 12'h004, 0);
		chk("status", q, 32'h4);
		apb(1, 12'h000, 3);
		do @(posedge pclk); while (deint_status !== 1'b1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rst_zero_sw", zero_int_sw, 1);
		chk("rst_deint", deint_status, 0);
		chk("rst_display", display_count, 0);
		chk("rst_gt", greater_than_flag, 0);
		presetn <= 1'b1;
		apb(0, 12'h000, 0);
		chk("rst_ctrl", q, 0);
		give_verdict;
	end
endmodule
